// file: wps_regs.svh
`ifndef WPS_REGS_SVH
`define WPS_REGS_SVH
// ***********************************
// Register map
// ***********************************
`define WPS_A_CTRL      8'h00
`define WPS_A_STATUS    8'h04
`define WPS_A_INT_FLAGS 8'h30
`define WPS_A_INT_CLEAR 8'h34
`define WPS_A_FCV       8'h78
`define WPS_CTRL_TRX    0
`define WPS_CTRL_EXT    1
`define WPS_CTRL_W      3
`define WPS_I_OC_WARN   0
`define WPS_I_OC_FAULT  1
`define WPS_I_OT_ALARM  2
`define WPS_I_OT_END    3
`define WPS_I_TSD       4
`define WPS_I_MAIN_OUTPUT_REGULATOR_ON   5
`define WPS_I_END_XFER  6
`define WPS_I_CONFLICT  7
`define WPS_I_AUTH_FAIL 8
`define WPS_I_FC_DONE   9
`define WPS_I_AUTH_OK   13
`define WPS_EPT_OC      3'h1
`define WPS_EPT_OT      3'h2
`define WPS_HDR_CE      8'h03
`define WPS_VOUT_DEF    16'h1388
`define WPS_STEP_CYC    16'h07d0
// ***********************************
// Timing
// ***********************************
`define WPS_CLK_HZ      64'd20000000
`define WPS_OTP_S       64'd180
`define WPS_BPP_S       64'd2
`define WPS_RPP_LIMIT   4'h8
`endif

// file: wps_pkg.sv
package wps_pkg;
  typedef struct packed {
    logic oc_warn;
    logic oc_hard;
    logic ot1;
    logic ot_cool;
    logic ot2;
    logic tsd;
    logic vrect_tgt;
    logic vrect_rng;
    logic rx_xfer;
    logic trx_ping;
    logic trx_xfer;
    logic ioc_inst;
    logic ioc_avg;
    logic ioc_ping;
    logic trx_ovp;
    logic trx_lvp;
    logic trx_ac;
    logic vout_sup;
  } wps_pins_t;

  typedef enum logic [2:0] {MAIN_OUTPUT_REGULATOR_IDLE, MAIN_OUTPUT_REGULATOR_RAMP, MAIN_OUTPUT_REGULATOR_CAL1, MAIN_OUTPUT_REGULATOR_ON, MAIN_OUTPUT_REGULATOR_TSD} wps_main_output_regulator_t;

  typedef struct packed {
    wps_pins_t s1;
    wps_pins_t s2;
    wps_pins_t s3;
    wps_pins_t lvl;
  } wps_sync_t;

  typedef struct packed {
    logic [31:0] cnt;
    logic        done;
  } wps_tmr_t;

  typedef struct packed {
    logic main_output_regulator_en;
    logic vout_9v;
    logic cep_high;
  } wps_pwr_t;
endpackage : wps_pkg

// file: wps_sync.sv
`timescale 1ns/1ps
module wps_sync
  import wps_pkg::*;
(
  input  wire logic      pclk,
  input  wire logic      presetn,
  input  wire logic      ce,
  input  wire wps_pins_t din,
  output wps_pins_t      dout
);
  wps_sync_t s_q;
  wps_sync_t s_d;

  // Level moves only when stages two and three agree
  always_comb begin
    s_d = s_q;
    s_d.s1 = din;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    s_d.lvl = (s_q.s2 & s_q.s3) | (s_q.lvl & (s_q.s2 | s_q.s3));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.lvl;
endmodule : wps_sync

// file: wps_timer.sv
`timescale 1ns/1ps
module wps_timer
  import wps_pkg::*;
#(
  parameter logic [31:0] CYCLES = 32'h0000_0010
)(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  input  wire logic run,
  output logic      expired
);
  wps_tmr_t t_q;
  wps_tmr_t t_d;

  // Dropping run clears the count, so a restart always gets the full time
  always_comb begin
    t_d = t_q;
    if (!run) begin
      t_d = '0;
    end else if (!t_q.done) begin
      t_d.cnt = t_q.cnt + 32'h1;
      t_d.done = (t_d.cnt >= CYCLES);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t_q <= '0;
    end else if (ce) begin
      t_q <= t_d;
    end
  end

  assign expired = t_q.done;
endmodule : wps_timer

// file: wps_supervisor.sv
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`include "wps_regs.svh"
module wps_supervisor
  import wps_pkg::*;
#(
  parameter logic [31:0] OTP_CYCLES = 32'(`WPS_OTP_S * `WPS_CLK_HZ),
  parameter logic [31:0] BPP_CYCLES = 32'(`WPS_BPP_S * `WPS_CLK_HZ),
  parameter logic [3:0]  RPP_LIMIT  = `WPS_RPP_LIMIT
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire wps_pins_t   pins_async,
  input  wire logic        rpp_sent,
  input  wire logic        tx_ack,
  input  wire logic        auth_done,
  input  wire logic        auth_pass,
  input  wire logic        demod_sop,
  input  wire logic        demod_valid,
  input  wire logic        demod_bit,
  output wps_pwr_t         pwr,
  output logic             ept_send,
  output logic [2:0]       ept_reason,
  output logic             reverse_transmit_mode,
  output logic             cep_ignore,
  output logic [7:0]       freq_adjust,
  output logic             freq_adjust_stb,
  output logic [15:0]      vout_setpoint,
  output logic             tx_vin_stb,
  output logic             interrupt_request_low_o,
  output logic             interrupt_request_low_oe
);
  // ***********************************
  // State
  // ***********************************
  typedef struct packed {
    wps_main_output_regulator_t               st;
    wps_pwr_t                pwr;
    logic [3:0]              rpp_cnt;
    logic                    otp_act;
    logic                    ot_ended;
    logic [15:0]             flags;
    logic [`WPS_CTRL_W-1:0]  ctrl;
    logic                    auth_ok;
    logic [15:0]             fcv;
    logic                    fc_go;
    logic [15:0]             vout_set;
    logic [15:0]             step_cnt;
    logic                    tx_vin_stb;
    logic                    trx_run;
    logic                    trx_lock;
    logic                    cep_ign;
    logic                    r_ping_oc;
    logic                    r_oc;
    logic                    r_ovp;
    logic                    ept_stb;
    logic [2:0]              ept_code;
    wps_pins_t               prev;
    logic [15:0]             sh;
    logic [3:0]              nb;
    logic [7:0]              adj;
    logic                    adj_stb;
    logic [31:0]             rdata;
    logic                    err;
    logic                    irq;
  } wps_sup_t;

  wps_sup_t  s_q;
  wps_sup_t  s_d;
  wps_pins_t p;
  logic      otp_exp;
  logic      bpp_exp;

  // ***********************************
  // Pin synchronisers and timers
  // ***********************************
  wps_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .din     (pins_async),
    .dout    (p)
  );

  wps_timer #(.CYCLES(OTP_CYCLES)) u_otp_tmr (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .run     (s_q.otp_act),
    .expired (otp_exp)
  );

  wps_timer #(.CYCLES(BPP_CYCLES)) u_bpp_tmr (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .run     (s_q.st == MAIN_OUTPUT_REGULATOR_RAMP),
    .expired (bpp_exp)
  );

  // ***********************************
  // Next state
  // ***********************************
  always_comb begin
    wps_pins_t   rise;
    logic [15:0] set;
    logic [15:0] clr;
    logic [15:0] pkt;
    logic        trx_start;
    rise = p & ~s_q.prev;
    set = '0;
    clr = '0;
    pkt = {s_q.sh[14:0], demod_bit};
    trx_start = 1'b0;
    s_d = s_q;
    s_d.prev = p;
    s_d.ept_stb = 1'b0;
    s_d.adj_stb = 1'b0;
    s_d.tx_vin_stb = 1'b0;

    // Register bus: read data captured in setup, zero wait states
    if (psel && !penable) begin
      s_d.err = 1'b0;
      s_d.rdata = '0;
      unique case (paddr)
        `WPS_A_CTRL:      s_d.rdata[`WPS_CTRL_W-1:0] = s_q.ctrl;
        `WPS_A_STATUS:    s_d.rdata[15:0] = {s_q.trx_lock, s_q.cep_ign, s_q.r_ovp, s_q.r_oc, s_q.r_ping_oc,
                                             s_q.trx_run, s_q.fc_go, s_q.auth_ok, s_q.otp_act,
                                             s_q.pwr, s_q.st, 1'b0};
        `WPS_A_INT_FLAGS: s_d.rdata[15:0] = s_q.flags;
        `WPS_A_INT_CLEAR: s_d.rdata = '0;
        `WPS_A_FCV:       s_d.rdata[15:0] = s_q.fcv;
        default:          s_d.err = 1'b1;
      endcase
    end
    if (psel && penable && pwrite) begin
      unique case (paddr)
        `WPS_A_CTRL: begin
          trx_start = pwdata[`WPS_CTRL_TRX] && !s_q.ctrl[`WPS_CTRL_TRX];
          s_d.ctrl = pwdata[`WPS_CTRL_W-1:0];
        end
        `WPS_A_INT_CLEAR: clr = pwdata[15:0];
        `WPS_A_FCV: begin
          // Request before authentication is dropped, no stale target
          if (s_q.auth_ok) begin
            s_d.fcv = pwdata[15:0];
            s_d.fc_go = 1'b1;
          end
        end
        default: ;
      endcase
    end

    // Receive mode: current and temperature
    if (rise.oc_warn) begin
      set[`WPS_I_OC_WARN] = 1'b1;
    end
    if (rise.oc_hard) begin
      set[`WPS_I_OC_FAULT] = 1'b1;
      s_d.ept_stb = 1'b1;
      s_d.ept_code = `WPS_EPT_OC;
    end
    if (rise.ot1) begin
      set[`WPS_I_OT_ALARM] = 1'b1;
      s_d.otp_act = 1'b1;
    end
    if (p.ot_cool) begin
      s_d.otp_act = 1'b0;
      s_d.ot_ended = 1'b0;
    end
    // One end packet per heating episode; a stale expiry after cooling is ignored
    if ((p.ot2 || (otp_exp && s_q.otp_act)) && !s_q.ot_ended && !rise.oc_hard) begin
      set[`WPS_I_OT_END] = 1'b1;
      s_d.ot_ended = 1'b1;
      s_d.ept_stb = 1'b1;
      s_d.ept_code = `WPS_EPT_OT;
    end

    // Main output enable sequencing
    unique case (s_q.st)
      MAIN_OUTPUT_REGULATOR_IDLE: begin
        s_d.pwr = '0;
        s_d.rpp_cnt = '0;
        if (p.rx_xfer) begin
          s_d.st = s_q.ctrl[`WPS_CTRL_EXT] ? MAIN_OUTPUT_REGULATOR_CAL1 : MAIN_OUTPUT_REGULATOR_RAMP;
        end
      end
      MAIN_OUTPUT_REGULATOR_RAMP: begin
        s_d.pwr.cep_high = 1'b1;
        if (p.vrect_tgt || bpp_exp) begin
          s_d.st = MAIN_OUTPUT_REGULATOR_ON;
          s_d.pwr.cep_high = 1'b0;
        end
      end
      MAIN_OUTPUT_REGULATOR_CAL1: begin
        if (tx_ack && p.vrect_rng) begin
          s_d.st = MAIN_OUTPUT_REGULATOR_ON;
        end else if (rpp_sent) begin
          s_d.rpp_cnt = s_q.rpp_cnt + 4'h1;
          if (s_d.rpp_cnt >= RPP_LIMIT) begin
            s_d.pwr.vout_9v = 1'b1;
            s_d.st = MAIN_OUTPUT_REGULATOR_ON;
          end
        end
      end
      MAIN_OUTPUT_REGULATOR_ON: begin
        s_d.pwr.main_output_regulator_en = 1'b1;
        if (!s_q.pwr.main_output_regulator_en) begin
          set[`WPS_I_MAIN_OUTPUT_REGULATOR_ON] = 1'b1;
        end
      end
      MAIN_OUTPUT_REGULATOR_TSD: begin
        s_d.pwr = '0;
      end
    endcase
    if (p.tsd && s_q.st != MAIN_OUTPUT_REGULATOR_TSD) begin
      s_d.st = MAIN_OUTPUT_REGULATOR_TSD;
      s_d.pwr = '0;
      set[`WPS_I_TSD] = 1'b1;
    end
    // Transfer loss overrides sequencing, also after shutdown; an auth_done in the same cycle still sets auth_ok
    if (!p.rx_xfer) begin
      s_d.st = MAIN_OUTPUT_REGULATOR_IDLE;
      s_d.pwr = '0;
      s_d.auth_ok = 1'b0;
      s_d.fc_go = 1'b0;
    end

    // Authentication and fast charge
    if (auth_done) begin
      s_d.auth_ok = auth_pass;
      set[`WPS_I_AUTH_OK] = auth_pass;
      set[`WPS_I_AUTH_FAIL] = !auth_pass;
    end
    if (s_q.fc_go && s_q.pwr.main_output_regulator_en) begin
      // Slow steps let the transmitter follow with its input
      s_d.step_cnt = s_q.step_cnt + 16'h1;
      if (s_q.step_cnt >= `WPS_STEP_CYC) begin
        s_d.step_cnt = '0;
        if (s_q.vout_set < s_q.fcv) begin
          s_d.vout_set = s_q.vout_set + 16'h1;
          s_d.tx_vin_stb = 1'b1;
        end else if (s_q.vout_set > s_q.fcv) begin
          s_d.vout_set = s_q.vout_set - 16'h1;
          s_d.tx_vin_stb = 1'b1;
        end else begin
          s_d.fc_go = 1'b0;
          set[`WPS_I_FC_DONE] = 1'b1;
        end
      end
    end

    // Reverse transmit
    if (!p.vout_sup) begin
      s_d.trx_lock = 1'b0;
    end
    if (trx_start && !s_q.trx_lock) begin
      s_d.trx_run = 1'b1;
      s_d.r_ping_oc = 1'b0;
      s_d.r_oc = 1'b0;
      s_d.r_ovp = 1'b0;
    end else if (trx_start) begin
      s_d.ctrl[`WPS_CTRL_TRX] = 1'b0;
    end
    if (s_q.trx_run) begin
      s_d.cep_ign = s_q.cep_ign && p.trx_xfer;
      if (p.trx_xfer && p.ioc_inst) begin
        s_d.cep_ign = 1'b1;
      end
      if (p.trx_ping && p.ioc_ping) begin
        s_d.r_ping_oc = 1'b1;
        s_d.trx_lock = 1'b1;
        s_d.trx_run = 1'b0;
        set[`WPS_I_END_XFER] = 1'b1;
      end
      if (p.trx_xfer && p.ioc_avg) begin
        s_d.r_oc = 1'b1;
        s_d.trx_lock = 1'b1;
        s_d.trx_run = 1'b0;
        set[`WPS_I_END_XFER] = 1'b1;
      end
      if (p.trx_ovp) begin
        s_d.r_ovp = 1'b1;
        s_d.trx_run = 1'b0;
        set[`WPS_I_END_XFER] = 1'b1;
      end
      if (rise.trx_lvp) begin
        set[`WPS_I_END_XFER] = 1'b1;
      end
      if (rise.trx_ac) begin
        set[`WPS_I_CONFLICT] = 1'b1;
        s_d.trx_run = 1'b0;
      end
      if (!s_d.trx_run) begin
        s_d.ctrl[`WPS_CTRL_TRX] = 1'b0;
        s_d.cep_ign = 1'b0;
      end
    end else begin
      s_d.cep_ign = 1'b0;
    end

    // Receiver packet decode: header byte then value byte
    if (demod_sop) begin
      s_d.nb = '0;
    end else if (demod_valid) begin
      s_d.sh = pkt;
      s_d.nb = s_q.nb + 4'h1;
      if (s_q.nb == 4'hf && pkt[15:8] == `WPS_HDR_CE && s_q.trx_run && !s_q.cep_ign) begin
        s_d.adj = pkt[7:0];
        s_d.adj_stb = 1'b1;
      end
    end

    // Set wins over a clear in the same cycle
    s_d.flags = (s_q.flags & ~clr) | set;
    s_d.irq = |s_d.flags;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.vout_set <= `WPS_VOUT_DEF;
      s_q.fcv <= `WPS_VOUT_DEF;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // ***********************************
  // Outputs
  // ***********************************
  assign prdata = s_q.rdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & s_q.err;
  assign pwr = s_q.pwr;
  assign ept_send = s_q.ept_stb;
  assign ept_reason = s_q.ept_code;
  assign reverse_transmit_mode = s_q.trx_run;
  assign cep_ignore = s_q.cep_ign;
  assign freq_adjust = s_q.adj;
  assign freq_adjust_stb = s_q.adj_stb;
  assign vout_setpoint = s_q.vout_set;
  assign tx_vin_stb = s_q.tx_vin_stb;
  assign interrupt_request_low_o = 1'b0;
  assign interrupt_request_low_oe = s_q.irq;
endmodule : wps_supervisor

// file: wps_supervisor_chk.sv
`timescale 1ns/1ps
module wps_supervisor_chk
  import wps_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic [7:0] paddr,
  input wire wps_pins_t  pins_async,
  input wire wps_pwr_t   pwr,
  input wire logic       ept_send,
  input wire logic [2:0] ept_reason,
  input wire logic       reverse_transmit_mode,
  input wire logic       cep_ignore,
  input wire logic       freq_adjust_stb,
  input wire logic       interrupt_request_low_o,
  input wire logic       interrupt_request_low_oe
);
  // ***********************************
  // Properties
  // ***********************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic clr_wr;
  // Helper is plain comb, sampled by the properties only
  assign clr_wr = psel && penable && pwrite && (paddr == 8'h34);

  a_line_low: assert property ((ept_send || $fell(reverse_transmit_mode)) |->
    (interrupt_request_low_oe && !interrupt_request_low_o))
    else $error("interrupt line not driven low on event");
  a_flag_latch: assert property ($fell(interrupt_request_low_oe) |-> $past(clr_wr))
    else $error("interrupt released without clear");
  a_ept_pulse: assert property (ept_send |=> !ept_send)
    else $error("end packet strobe too long");
  a_oc_end: assert property ($rose(pins_async.oc_hard) |-> ##[2:10] (ept_send && ept_reason == 3'h1))
    else $error("no over-current end packet");
  a_tsd_off: assert property (pins_async.tsd [*7] |=> !pwr.main_output_regulator_en)
    else $error("regulator on in shutdown");
  a_ping_stop: assert property ((pins_async.ioc_ping && pins_async.trx_ping) [*8] |=> !reverse_transmit_mode)
    else $error("ping over-current did not stop");
  a_ovp_stop: assert property (pins_async.trx_ovp [*8] |=> !reverse_transmit_mode)
    else $error("over-voltage did not stop");
  a_avg_stop: assert property ((pins_async.ioc_avg && pins_async.trx_xfer) [*8] |=> !reverse_transmit_mode)
    else $error("average over-current did not stop");
  a_cep_ign: assert property ((pins_async.ioc_inst && pins_async.trx_xfer && reverse_transmit_mode) [*8]
    |-> cep_ignore)
    else $error("control errors not disregarded");
  a_conflict: assert property ($rose(pins_async.trx_ac) && reverse_transmit_mode |->
    ##[2:8] !reverse_transmit_mode)
    else $error("conflict did not stop");

  c_ot_end: cover property (ept_send && ept_reason == 3'h2);
  c_demod: cover property (freq_adjust_stb);
  c_low_tgt: cover property ($rose(pwr.vout_9v));
endmodule : wps_supervisor_chk

bind wps_supervisor wps_supervisor_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pins_async(pins_async), .pwr(pwr), .ept_send(ept_send),
  .ept_reason(ept_reason), .reverse_transmit_mode(reverse_transmit_mode), .cep_ignore(cep_ignore),
  .freq_adjust_stb(freq_adjust_stb), .interrupt_request_low_o(interrupt_request_low_o),
  .interrupt_request_low_oe(interrupt_request_low_oe));

// file: wps_peer.sv
`timescale 1ns/1ps
module wps_peer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        send,
  input  wire logic [15:0] word,
  output logic             demod_sop,
  output logic             demod_valid,
  output logic             demod_bit
);
  // ***********************************
  // Packet shifter
  // ***********************************
  logic [15:0] sh_q;
  logic [4:0]  cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_q <= 16'h0000;
      cnt_q <= 5'h00;
      demod_sop <= 1'b0;
      demod_valid <= 1'b0;
      demod_bit <= 1'b0;
    end else begin
      demod_sop <= 1'b0;
      demod_valid <= 1'b0;
      if (send) begin
        sh_q <= word;
        cnt_q <= 5'h10;
        demod_sop <= 1'b1;
      end else if (cnt_q != 5'h00 && !demod_valid) begin
        demod_valid <= 1'b1;
        demod_bit <= sh_q[15];
        sh_q <= {sh_q[14:0], 1'b0};
        cnt_q <= cnt_q - 5'h01;
      end else if (!demod_valid) begin
        // Idle line toggles so a stale bit never passes for data
        demod_bit <= ~demod_bit;
      end
    end
  end
endmodule : wps_peer

// file: tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin error_cnt++; \
  $display("ERROR %s exp %0h got %0h", nm, ex, got); end end
module tb_top
  import wps_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr, freq_adjust;
  logic [31:0] pwdata, prdata, rd;
  logic        rpp_sent, tx_ack, auth_done, auth_pass, pk_send, demod_sop, demod_valid, demod_bit;
  logic        ept_send, reverse_transmit_mode, cep_ignore, freq_adjust_stb, tx_vin_stb;
  logic        interrupt_request_low_o, interrupt_request_low_oe;
  logic [15:0] pk_word, vout_setpoint;
  logic [2:0]  ept_reason, ept_r;
  wps_pins_t   pins;
  wps_pwr_t    pwr;
  wire         irq_n;
  int          error_cnt, n_compared, cyc, ept_n, fa_n, vin_n, n;

  // Open-drain line with pull-up
  assign irq_n = interrupt_request_low_oe ? interrupt_request_low_o : 1'b1;
  initial pclk = 1'b0;
  always #25 pclk = ~pclk;

  wps_supervisor #(.OTP_CYCLES(32'h0000_00c8), .BPP_CYCLES(32'h0000_0064), .RPP_LIMIT(4'h8)) dut (
    .pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .pins_async(pins), .rpp_sent, .tx_ack, .auth_done, .auth_pass, .demod_sop, .demod_valid, .demod_bit,
    .pwr, .ept_send, .ept_reason, .reverse_transmit_mode, .cep_ignore, .freq_adjust, .freq_adjust_stb,
    .vout_setpoint, .tx_vin_stb, .interrupt_request_low_o, .interrupt_request_low_oe);
  wps_peer u_peer (.pclk, .presetn, .send(pk_send), .word(pk_word), .demod_sop, .demod_valid, .demod_bit);

  // ***********************************
  // Monitors and watchdog
  // ***********************************
  // Sampled on the falling edge where registered outputs are settled
  always @(negedge pclk) begin
    cyc++;
    if (ept_send === 1'b1) begin
      ept_n++;
      ept_r = ept_reason;
    end
    if (freq_adjust_stb === 1'b1) fa_n++;
    if (tx_vin_stb === 1'b1) vin_n++;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic cy(input int k);
    repeat (k) @(posedge pclk);
  endtask : cy

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb

  // ***********************************
  // Scenarios
  // ***********************************
  task automatic t_reset;
    apb(1'b0, 8'h30, 32'h0);
    `CHK("flags_rst", 32'h0, rd)
    `CHK("irq_rst", 1'b1, irq_n)
    apb(1'b0, 8'h10, 32'h0);
    `CHK("unmapped", 1'b1, er)
  endtask : t_reset

  task automatic t_oc;
    pins.oc_warn <= 1'b1;
    cy(8);
    pins.oc_warn <= 1'b0;
    cy(8);
    apb(1'b0, 8'h30, 32'h0);
    `CHK("oc_warn", 1'b1, rd[0])
    `CHK("irq_low", 1'b0, irq_n)
    apb(1'b1, 8'h34, 32'h1);
    cy(3);
    `CHK("irq_clr", 1'b1, irq_n)
    n = ept_n;
    pins.oc_hard <= 1'b1;
    cy(10);
    pins.oc_hard <= 1'b0;
    apb(1'b0, 8'h30, 32'h0);
    `CHK("oc_flag", 1'b1, rd[1])
    `CHK("oc_ept", n + 1, ept_n)
    `CHK("oc_why", 3'h1, ept_r)
  endtask : t_oc

  task automatic t_ot;
    pins.ot1 <= 1'b1;
    cy(8);
    apb(1'b0, 8'h30, 32'h0);
    `CHK("ot_alarm", 1'b1, rd[2])
    n = ept_n;
    cy(140);
    {pins.ot1, pins.ot_cool} <= 2'b01;
    cy(8);
    {pins.ot1, pins.ot_cool} <= 2'b10;
    cy(150);
    `CHK("ot_restart", n, ept_n)
    cy(80);
    `CHK("ot_expire", n + 1, ept_n)
    `CHK("ot_why", 3'h2, ept_r)
    {pins.ot1, pins.ot_cool} <= 2'b01;
    cy(8);
    {pins.ot1, pins.ot2, pins.ot_cool} <= 3'b110;
    cy(10);
    `CHK("ot2_ept", n + 2, ept_n)
    {pins.ot1, pins.ot2, pins.ot_cool} <= 3'b001;
  endtask : t_ot

  task automatic t_basic;
    pins.rx_xfer <= 1'b1;
    cy(8);
    `CHK("cep_high", 3'b001, pwr)
    pins.vrect_tgt <= 1'b1;
    cy(8);
    `CHK("ldo_on", 3'b100, pwr)
    n = vin_n;
    apb(1'b1, 8'h78, 32'h1389);
    cy(2100);
    `CHK("fc_refused", 16'h1388, vout_setpoint)
    {auth_done, auth_pass} <= 2'b10;
    cy(1);
    {auth_done, auth_pass} <= 2'b11;
    cy(1);
    {auth_done, auth_pass} <= 2'b00;
    cy(4);
    apb(1'b0, 8'h30, 32'h0);
    `CHK("auth_fail", 1'b1, rd[8])
    `CHK("auth_ok", 1'b1, rd[13])
    apb(1'b1, 8'h78, 32'h1389);
    cy(2010);
    `CHK("fc_step", 16'h1389, vout_setpoint)
    `CHK("fc_vin", n + 1, vin_n)
    pins.tsd <= 1'b1;
    cy(8);
    `CHK("tsd_off", 1'b0, pwr.main_output_regulator_en)
    {pins.rx_xfer, pins.tsd, pins.vrect_tgt} <= 3'b000;
    cy(8);
    // Rectifier never reaches target: the 100-cycle timer must enable
    pins.rx_xfer <= 1'b1;
    cy(8);
    `CHK("bpp_wait", 1'b0, pwr.main_output_regulator_en)
    cy(110);
    `CHK("bpp_expire", 1'b1, pwr.main_output_regulator_en)
    pins.rx_xfer <= 1'b0;
    cy(8);
  endtask : t_basic

  task automatic t_ext;
    apb(1'b1, 8'h00, 32'h2);
    pins.rx_xfer <= 1'b1;
    cy(8);
    for (int i = 0; i < 8; i++) begin
      `CHK("ldo_wait", 1'b0, pwr.main_output_regulator_en)
      rpp_sent <= 1'b1;
      cy(1);
      rpp_sent <= 1'b0;
      cy(2);
    end
    cy(3);
    `CHK("low_tgt", 2'b11, {pwr.main_output_regulator_en, pwr.vout_9v})
    pins.rx_xfer <= 1'b0;
    cy(8);
    {pins.rx_xfer, pins.vrect_rng} <= 2'b11;
    cy(8);
    `CHK("ack_wait", 1'b0, pwr.main_output_regulator_en)
    tx_ack <= 1'b1;
    cy(1);
    tx_ack <= 1'b0;
    cy(3);
    `CHK("ack_on", 1'b1, pwr.main_output_regulator_en)
    {pins.rx_xfer, pins.vrect_rng} <= 2'b00;
  endtask : t_ext

  task automatic restart;
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h00, 32'h1);
    cy(3);
  endtask : restart

  task automatic t_trx;
    {pins.vout_sup, pins.trx_ping} <= 2'b11;
    restart();
    n = fa_n;
    pk_word <= 16'h035a;
    pk_send <= 1'b1;
    cy(1);
    pk_send <= 1'b0;
    cy(45);
    `CHK("demod", 8'h5a, freq_adjust)
    pk_word <= 16'h045a;
    pk_send <= 1'b1;
    cy(1);
    pk_send <= 1'b0;
    cy(45);
    `CHK("demod_hdr", n + 1, fa_n)
    pins.ioc_ping <= 1'b1;
    cy(10);
    pins.ioc_ping <= 1'b0;
    apb(1'b0, 8'h04, 32'h0);
    `CHK("ping_stat", 2'b11, {rd[15], rd[11]})
    restart();
    `CHK("locked", 1'b0, reverse_transmit_mode)
    pins.vout_sup <= 1'b0;
    cy(8);
    pins.vout_sup <= 1'b1;
    restart();
    `CHK("unlocked", 1'b1, reverse_transmit_mode)
    apb(1'b1, 8'h34, 32'hffff);
    pins.trx_lvp <= 1'b1;
    cy(8);
    apb(1'b0, 8'h30, 32'h0);
    `CHK("lvp", 2'b11, {rd[6], reverse_transmit_mode})
    pins.trx_ovp <= 1'b1;
    cy(10);
    apb(1'b0, 8'h04, 32'h0);
    `CHK("ovp", 2'b10, {rd[13], reverse_transmit_mode})
    {pins.trx_ovp, pins.trx_lvp} <= 2'b00;
    restart();
    pins.trx_ac <= 1'b1;
    cy(10);
    apb(1'b0, 8'h30, 32'h0);
    `CHK("conflict", 2'b10, {rd[7], reverse_transmit_mode})
    {pins.trx_ac, pins.trx_ping, pins.trx_xfer} <= 3'b001;
    restart();
    pins.ioc_inst <= 1'b1;
    cy(10);
    `CHK("cep_ign", 1'b1, cep_ignore)
    pins.ioc_avg <= 1'b1;
    cy(10);
    apb(1'b0, 8'h04, 32'h0);
    `CHK("avg_oc", 2'b10, {rd[12], reverse_transmit_mode})
    pins.vout_sup <= 1'b0;
  endtask : t_trx

  task automatic report_and_stop;
    if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {rpp_sent, tx_ack, auth_done, auth_pass, pk_send, pk_word} = '0;
    pins = '0;
    presetn = 1'b0;
    cy(5);
    presetn <= 1'b1;
    t_reset();
    t_oc();
    t_ot();
    t_basic();
    t_ext();
    t_trx();
    report_and_stop();
  end
endmodule : tb_top
